// *** rtl/asci_pkg.sv ***
// constants shared by the asynchronous serial interface
package asci_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] RATE_IDX = 8'h10;
	localparam logic [7:0] CSR_IDX  = 8'h11;
	localparam logic [7:0] RXD_IDX  = 8'h12;
	localparam logic [7:0] TXD_IDX  = 8'h13;
	localparam logic [9:0] RATE_ADDR = {RATE_IDX, 2'b00};
	localparam logic [9:0] CSR_ADDR  = {CSR_IDX, 2'b00};
	localparam logic [9:0] RXD_ADDR  = {RXD_IDX, 2'b00};
	localparam logic [9:0] TXD_ADDR  = {TXD_IDX, 2'b00};
	// control/status bit positions
	localparam int WU_BIT   = 0;
	localparam int TE_BIT   = 1;
	localparam int TIE_BIT  = 2;
	localparam int RE_BIT   = 3;
	localparam int RIE_BIT  = 4;
	localparam int TX_EMPTY_FLAG_BIT = 5;
	localparam int OVERRUN_FRAMING_FLAG_BIT = 6;
	localparam int RX_FULL_FLAG_BIT = 7;
	// reset values
	localparam logic [3:0] RATE_RESET = 4'h0;
	localparam logic [7:0] CSR_RESET  = 8'h20;
	// clock control codes
	localparam logic [1:0] CC_BIPHASE = 2'h0;
	localparam logic [1:0] CC_NRZ     = 2'h1;
	localparam logic [1:0] CC_CLKOUT  = 2'h2;
	localparam logic [1:0] CC_EXT     = 2'h3;
	// eighth-bit tick masks on the timer counter: bit time 16/128/1024/4096
	localparam logic [15:0] TICK_MASK0 = 16'h0001;
	localparam logic [15:0] TICK_MASK1 = 16'h000F;
	localparam logic [15:0] TICK_MASK2 = 16'h007F;
	localparam logic [15:0] TICK_MASK3 = 16'h01FF;
	// timer bit whose period equals one bit time, for the clock output
	localparam int CLKOUT_BIT0 = 3;
	localparam int CLKOUT_BIT1 = 6;
	localparam int CLKOUT_BIT2 = 9;
	localparam int CLKOUT_BIT3 = 11;
	// frame and sequence counts
	localparam logic [3:0] PRE_BITS  = 4'h9;
	localparam logic [3:0] IDLE_ONES = 4'hA;
	localparam logic [3:0] TX_BITS   = 4'h9;
	localparam logic [2:0] PH_LAST   = 3'h7;
	localparam logic [2:0] PH_MID    = 3'h3;
	localparam logic [2:0] RX_LAST   = 3'h7;
	typedef enum logic [1:0] {TX_OFF, TX_PRE, TX_RUN} asci_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asci_rx_e;
endpackage

// *** rtl/asci_top.sv ***
// asynchronous serial interface with apb register access
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module asci_top import asci_pkg::*; (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [9:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// timer free-running counter
	input  wire logic [15:0] timer_count,
	// port 2 direction bits 2..4
	input  wire logic        ddr_wr,
	input  wire logic [2:0]  ddr_wdata,
	output logic      [2:0]  ddr_q,
	// serial pins
	input  wire logic        serial_clock_pin_in,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe,
	input  wire logic        serial_rx_pin_in,
	output logic             serial_tx_pin_out,
	output logic             serial_tx_pin_oe,
	// interrupt request
	output logic             internal_irq_line
);
	logic [3:0]  rate_q, rate_d;
	logic [4:0]  ctl_q, ctl_d;
	logic        tx_empty_flag_q, tx_empty_flag_d, overrun_framing_flag_q, overrun_framing_flag_d, rx_full_flag_q, rx_full_flag_d;
	logic [2:0]  seen_q, seen_d;
	logic [7:0]  tdr_q, tdr_d, rdr_q, rdr_d;
	logic [31:0] prdata_q, prdata_d;
	logic [2:0]  ddr_d;
	logic        ext_s1_q, ext_s2_q, ext_s3_q, rx_s1_q, rx_s2_q, clkout_q, clkout_d;
	asci_tx_e    tx_st_q, tx_st_d;
	logic [2:0]  tph_q, tph_d;
	logic [3:0]  pre_q, pre_d, tcnt_q, tcnt_d;
	logic [8:0]  tsh_q, tsh_d;
	logic        tline_q, tline_d, tbit_q, tbit_d, te_prev_q;
	asci_rx_e    rx_st_q, rx_st_d;
	logic [2:0]  rph_q, rph_d, rcnt_q, rcnt_d, iph_q, iph_d;
	logic [7:0]  rsh_q, rsh_d;
	logic [3:0]  ones_q, ones_d;
	logic        tick, acc, wr, rd, hit, tx_load, rx_done, rx_bad, line_idle;
	logic [15:0] tmask;
	logic [1:0]  cc;
	logic        wu, te, tx_irq_enable, re, rx_irq_enable;

	assign cc  = rate_q[3:2];
	assign wu  = ctl_q[WU_BIT];
	assign te  = ctl_q[TE_BIT];
	assign tx_irq_enable = ctl_q[TIE_BIT];
	assign re  = ctl_q[RE_BIT];
	assign rx_irq_enable = ctl_q[RIE_BIT];

	// eighth-bit tick from the timer counter, or from the external clock edge
	always_comb begin
		case (rate_q[1:0])
			2'h0: tmask = TICK_MASK0;
			2'h1: tmask = TICK_MASK1;
			2'h2: tmask = TICK_MASK2;
			default: tmask = TICK_MASK3;
		endcase
		// a cpu write to the timer shifts these ticks
		tick = (cc == CC_EXT) ? (ext_s2_q & ~ext_s3_q)
			: ((timer_count & tmask) == tmask);
		case (rate_q[1:0])
			2'h0: clkout_d = timer_count[CLKOUT_BIT0];
			2'h1: clkout_d = timer_count[CLKOUT_BIT1];
			2'h2: clkout_d = timer_count[CLKOUT_BIT2];
			default: clkout_d = timer_count[CLKOUT_BIT3];
		endcase
	end

	// pin synchronisers, two flops before any logic looks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			rx_s1_q  <= 1'b1;
			rx_s2_q  <= 1'b1;
			clkout_q <= 1'b0;
		end else begin
			ext_s1_q <= serial_clock_pin_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			rx_s1_q  <= serial_rx_pin_in;
			rx_s2_q  <= rx_s1_q;
			clkout_q <= clkout_d;
		end
	end

	// apb decode; zero-wait, read data latched in the setup cycle
	assign acc    = psel & penable;
	assign wr     = acc & pwrite & pstrb[0];
	assign rd     = acc & ~pwrite;
	assign hit    = (paddr == RATE_ADDR) | (paddr == CSR_ADDR)
		| (paddr == RXD_ADDR) | (paddr == TXD_ADDR);
	assign pready = 1'b1;
	assign pslverr = acc & ~hit; // unmapped answers with an error
	assign prdata = prdata_q;

	always_comb begin
		prdata_d = prdata_q;
		if (psel & ~penable) begin
			case (paddr)
				CSR_ADDR: prdata_d = {24'h000000, rx_full_flag_q, overrun_framing_flag_q, tx_empty_flag_q, ctl_q};
				RXD_ADDR: prdata_d = {24'h000000, rdr_q};
				default:  prdata_d = 32'h00000000; // rate and tx data are write-only
			endcase
		end
	end

	// direction bits, locked while the owning enable holds them
	always_comb begin
		ddr_d = ddr_wr ? ddr_wdata : ddr_q;
		if (cc[1])
			ddr_d[0] = ~cc[0];
		if (re)
			ddr_d[1] = 1'b0;
		if (te)
			ddr_d[2] = 1'b1;
	end

	// pin drive; port data outside this block is not modelled
	always_comb begin
		serial_clock_pin_oe  = ddr_q[0];
		serial_clock_pin_out = (cc == CC_CLKOUT) & clkout_q;
		serial_tx_pin_oe     = ddr_q[2];
		serial_tx_pin_out    = te ? tline_q : 1'b1;
		internal_irq_line    = (tx_irq_enable & tx_empty_flag_q) | (rx_irq_enable & (rx_full_flag_q | overrun_framing_flag_q));
	end

	// transmitter: preamble, idle ones, framed bytes
	always_comb begin
		logic bstart, bmid, b;
		bstart  = tick & (tph_q == PH_LAST);
		bmid    = tick & (tph_q == PH_MID);
		b       = 1'b1;
		tx_load = 1'b0;
		tx_st_d = tx_st_q;
		tph_d   = tick ? tph_q + 3'h1 : tph_q;
		pre_d   = pre_q;
		tcnt_d  = tcnt_q;
		tsh_d   = tsh_q;
		tline_d = tline_q;
		tbit_d  = tbit_q;
		case (tx_st_q)
			TX_OFF: begin
				tph_d   = 3'h0;
				tline_d = 1'b1;
				if (te & ~te_prev_q) begin
					tx_st_d = TX_PRE;
					pre_d   = PRE_BITS;
				end
			end
			TX_PRE: begin
				if (bstart) begin
					pre_d = pre_q - 4'h1;
					if (pre_q == 4'h1) begin
						tx_st_d = TX_RUN;
						tcnt_d  = 4'h0;
					end
				end
			end
			TX_RUN: begin
				if (bstart) begin
					if (tcnt_q != 4'h0) begin
						b      = tsh_q[0];
						tsh_d  = {1'b1, tsh_q[8:1]};
						tcnt_d = tcnt_q - 4'h1;
					end else if (!tx_empty_flag_q) begin
						tx_load = 1'b1;
						b       = 1'b0;
						tsh_d   = {1'b1, tdr_q};
						tcnt_d  = TX_BITS;
					end
				end
			end
			default: tx_st_d = TX_OFF;
		endcase
		if (tx_st_q != TX_OFF & bstart) begin
			tbit_d  = b;
			tline_d = (cc == CC_BIPHASE) ? ~tline_q : b;
		end
		if (tx_st_q != TX_OFF & bmid & (cc == CC_BIPHASE) & tbit_q)
			tline_d = ~tline_q;
		if (!te)
			tx_st_d = TX_OFF;
	end

	// receiver: eight samples a bit, start on a low, mid-bit sampling
	always_comb begin
		rx_done = 1'b0;
		rx_bad  = 1'b0;
		rx_st_d = rx_st_q;
		rph_d   = tick ? rph_q + 3'h1 : rph_q;
		rcnt_d  = rcnt_q;
		rsh_d   = rsh_q;
		iph_d   = tick ? iph_q + 3'h1 : iph_q;
		ones_d  = ones_q;
		if (tick & (iph_q == PH_LAST))
			ones_d = !rx_s2_q ? 4'h0 : (ones_q == IDLE_ONES) ? ones_q : ones_q + 4'h1;
		case (rx_st_q)
			RX_IDLE: begin
				if (tick & ~rx_s2_q) begin
					rx_st_d = RX_START;
					rph_d   = 3'h0;
				end
			end
			RX_START: begin
				if (tick & (rph_q == PH_MID)) begin
					rph_d   = 3'h0;
					rcnt_d  = 3'h0;
					rx_st_d = rx_s2_q ? RX_IDLE : RX_DATA; // glitch rejected
				end
			end
			RX_DATA: begin
				if (tick & (rph_q == PH_LAST)) begin
					rsh_d  = {rx_s2_q, rsh_q[7:1]};
					rcnt_d = rcnt_q + 3'h1;
					if (rcnt_q == RX_LAST)
						rx_st_d = RX_STOP;
				end
			end
			RX_STOP: begin
				if (tick & (rph_q == PH_LAST)) begin
					rx_done = 1'b1;
					rx_bad  = ~rx_s2_q;
					rx_st_d = RX_IDLE;
				end
			end
			default: rx_st_d = RX_IDLE;
		endcase
		if (!re) begin
			rx_st_d = RX_IDLE;
			iph_d   = 3'h0;
			ones_d  = 4'h0;
		end
	end
	assign line_idle = (ones_q == IDLE_ONES);

	// registers and flags; hardware sets win over software clears
	always_comb begin
		logic csr_rd, rxd_rd, blocked;
		csr_rd  = rd & (paddr == CSR_ADDR);
		rxd_rd  = rd & (paddr == RXD_ADDR);
		blocked = overrun_framing_flag_q & ~rx_full_flag_q; // framing error pending
		rate_d  = rate_q;
		ctl_d   = ctl_q;
		tx_empty_flag_d  = tx_empty_flag_q;
		overrun_framing_flag_d  = overrun_framing_flag_q;
		rx_full_flag_d  = rx_full_flag_q;
		seen_d  = seen_q;
		tdr_d   = tdr_q;
		rdr_d   = rdr_q;
		if (wr & (paddr == RATE_ADDR))
			rate_d = pwdata[3:0];
		if (wr & (paddr == CSR_ADDR)) begin
			ctl_d[4:1] = pwdata[4:1];
			ctl_d[WU_BIT] = pwdata[WU_BIT] & ~line_idle;
		end
		if (line_idle)
			ctl_d[WU_BIT] = 1'b0;
		if (csr_rd)
			seen_d = prdata_q[7:5];
		if (wr & (paddr == TXD_ADDR)) begin
			tdr_d = pwdata[7:0];
			if (seen_q[0]) begin
				tx_empty_flag_d    = 1'b0;
				seen_d[0] = 1'b0;
			end
		end
		if (rxd_rd) begin
			if (seen_q[1])
				overrun_framing_flag_d = 1'b0;
			if (seen_q[2])
				rx_full_flag_d = 1'b0;
			seen_d[2:1] = 2'h0;
		end
		if (tx_load)
			tx_empty_flag_d = 1'b1;
		if (rx_done & ~wu) begin
			if (rx_full_flag_q)
				overrun_framing_flag_d = 1'b1;
			else if (!blocked) begin
				rdr_d = rsh_q;
				if (rx_bad)
					overrun_framing_flag_d = 1'b1;
				else
					rx_full_flag_d = 1'b1;
			end
		end
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_q    <= RATE_RESET;
			ctl_q     <= CSR_RESET[4:0];
			tx_empty_flag_q    <= CSR_RESET[TX_EMPTY_FLAG_BIT];
			overrun_framing_flag_q    <= CSR_RESET[OVERRUN_FRAMING_FLAG_BIT];
			rx_full_flag_q    <= CSR_RESET[RX_FULL_FLAG_BIT];
			seen_q    <= 3'h0;
			tdr_q     <= 8'h00;
			rdr_q     <= 8'h00;
			prdata_q  <= 32'h00000000;
			ddr_q     <= 3'h0;
			tx_st_q   <= TX_OFF;
			tph_q     <= 3'h0;
			pre_q     <= 4'h0;
			tcnt_q    <= 4'h0;
			tsh_q     <= 9'h1FF;
			tline_q   <= 1'b1;
			tbit_q    <= 1'b1;
			te_prev_q <= 1'b0;
			rx_st_q   <= RX_IDLE;
			rph_q     <= 3'h0;
			rcnt_q    <= 3'h0;
			rsh_q     <= 8'h00;
			iph_q     <= 3'h0;
			ones_q    <= 4'h0;
		end else begin
			rate_q    <= rate_d;
			ctl_q     <= ctl_d;
			tx_empty_flag_q    <= tx_empty_flag_d;
			overrun_framing_flag_q    <= overrun_framing_flag_d;
			rx_full_flag_q    <= rx_full_flag_d;
			seen_q    <= seen_d;
			tdr_q     <= tdr_d;
			rdr_q     <= rdr_d;
			prdata_q  <= prdata_d;
			ddr_q     <= ddr_d;
			tx_st_q   <= tx_st_d;
			tph_q     <= tph_d;
			pre_q     <= pre_d;
			tcnt_q    <= tcnt_d;
			tsh_q     <= tsh_d;
			tline_q   <= tline_d;
			tbit_q    <= tbit_d;
			te_prev_q <= te;
			rx_st_q   <= rx_st_d;
			rph_q     <= rph_d;
			rcnt_q    <= rcnt_d;
			rsh_q     <= rsh_d;
			iph_q     <= iph_d;
			ones_q    <= ones_d;
		end
	end

	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_te_rise;
		(tx_st_q == TX_OFF) && te && !te_prev_q && (cc != CC_BIPHASE);
	endsequence
	sequence s_ones8;
		serial_tx_pin_out [*8];
	endsequence

	chk_irq_tx_level: assert property ((tx_irq_enable && tx_empty_flag_q) |-> internal_irq_line)
		else $error("tx interrupt missing");
	chk_irq_rx_level: assert property (internal_irq_line
		== ((tx_irq_enable && tx_empty_flag_q) || (rx_irq_enable && (rx_full_flag_q || overrun_framing_flag_q))))
		else $error("irq line wrong");
	chk_ddr_tx_lock: assert property (te |=> ddr_q[2])
		else $error("tx direction not locked");
	chk_ddr_rx_lock: assert property (re |=> !ddr_q[1])
		else $error("rx direction not locked");
	chk_clk_dir_force: assert property (cc[1] |=> ddr_q[0] == !$past(cc[0]))
		else $error("clock pin direction not forced");
	chk_tx_empty_flag_on_load: assert property (tx_load |=> tx_empty_flag_q)
		else $error("empty flag not set on load");
	chk_start_bit: assert property (tx_load && cc != CC_BIPHASE |=> !tline_q)
		else $error("start bit not zero");
	chk_overrun_keep: assert property (rx_done && !wu && rx_full_flag_q
		|=> overrun_framing_flag_q && rx_full_flag_q && rdr_q == $past(rdr_q))
		else $error("overrun overwrote data");
	chk_wu_idle_clear: assert property (line_idle |=> !wu)
		else $error("wake-up not cleared on idle");
	chk_preamble_ones: assert property (s_te_rise |=> s_ones8)
		else $error("preamble not ones");
	chk_wu_no_flags: assert property (wu && rx_done && !rx_full_flag_q
		|=> $stable(rdr_q) && !$rose(rx_full_flag_q))
		else $error("flags set while wake-up armed");
endmodule // asci_top

// *** testbench/asci_far_end.sv ***
// far-end serial port model: sends frames to the receiver, decodes the transmitter
`timescale 1ns/100ps
module asci_far_end (
	// clock
	input  wire logic       clk,
	// serial lines
	input  wire logic       tx_line,
	output logic            rx_line,
	// decoded frame, stop bit on top
	output logic [8:0]      got,
	output logic            got_stb
);
	int bit_cycles = 16;
	bit listen     = 1'b1;

	// start zero, data lsb first, stop bit; then idle high so the next start is clean
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			repeat (bit_cycles) @(posedge clk);
		end
		rx_line <= 1'b1;
		repeat (2 * bit_cycles) @(posedge clk);
	endtask

	// falling edge opens a frame; sampling at mid-bit tolerates tick phase
	initial begin
		rx_line = 1'b1;
		got     = 9'h000;
		got_stb = 1'b0;
		forever begin
			@(posedge clk);
			got_stb <= 1'b0;
			if (listen && tx_line === 1'b0) begin
				repeat (bit_cycles / 2) @(posedge clk);
				for (int i = 0; i < 9; i++) begin
					repeat (bit_cycles) @(posedge clk);
					got[i] <= tx_line;
				end
				got_stb <= 1'b1;
			end
		end
	end
endmodule // asci_far_end

// *** testbench/tb_top.sv ***
// self-checking bench for the asynchronous serial interface
`timescale 1ns/100ps
module tb_top import asci_pkg::*; ();
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ddr_wr;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, rd_val;
	logic [3:0]  pstrb;
	logic [15:0] timer_count;
	logic [2:0]  ddr_wdata, ddr_q;
	logic        clk_out, tx_out, rx_line, irq, got_stb, err_seen, ext_clk;
	logic [8:0]  got;
	logic [7:0]  b1, b2;
	logic [7:0]  exp_q[$];
	int          n_mismatch, check_count, k;

	asci_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_count(timer_count),
		.ddr_wr(ddr_wr), .ddr_wdata(ddr_wdata), .ddr_q(ddr_q), .serial_clock_pin_in(ext_clk),
		.serial_clock_pin_out(clk_out), .serial_clock_pin_oe(), .serial_rx_pin_in(rx_line),
		.serial_tx_pin_out(tx_out), .serial_tx_pin_oe(), .internal_irq_line(irq));
	asci_far_end far_u (.clk(pclk), .tx_line(tx_out), .rx_line(rx_line), .got(got),
		.got_stb(got_stb));

	// clock and free-running timer, which paces the bit clock
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) timer_count <= timer_count + 16'h0001;
	// far-end clock for code 11: eight cycles a period, even duty, well below pclk/4
	always @(posedge pclk) ext_clk <= timer_count[2];

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer; the leading edge keeps back-to-back calls from colliding
	task automatic apb(input logic [9:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h000000, d};
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) n_mismatch++;
		rd_val = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a);
		apb(a, 1'b0, 8'h00);
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		apb(a, 1'b1, d);
	endtask

	// transitions of the tx pin or the clock pin over 64 cycles
	task automatic toggles(input bit pick, output int n);
		logic p, c;
		n = 0;
		@(posedge pclk);
		p = pick ? tx_out : clk_out;
		repeat (64) begin
			@(posedge pclk);
			c = pick ? tx_out : clk_out;
			if (c !== p) n++;
			p = c;
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// each decoded frame is compared with the oldest byte queued for sending
	always @(posedge pclk) begin
		if (got_stb === 1'b1) begin
			if (exp_q.size() > 0) chk("tx frame", {23'h0, got}, {24'h1, exp_q.pop_front()});
			else chk("tx unexpected", 32'h1, 32'h0);
		end
	end

	// watchdog, well beyond the longest expected run
	initial begin
		repeat (80000) @(posedge pclk);
		n_mismatch++;
		results();
	end

	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 10'h000;
		pwdata = 32'h0; pstrb = 4'hF; ddr_wr = 0; ddr_wdata = 3'h0; timer_count = 16'h0000;
		void'($urandom(64746));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(CSR_ADDR); chk("csr reset", rd_val, 32'h20);
		rd(RATE_ADDR); chk("rate read", rd_val, 32'h0);
		rd(10'h3FC); chk("unmapped", {31'h0, err_seen}, 32'h1);
		chk("ddr reset", {29'h0, ddr_q}, 32'h0);
		wr(RATE_ADDR, 8'h04);
		wr(CSR_ADDR, 8'h1E);
		@(posedge pclk); ddr_wr <= 1'b1; ddr_wdata <= 3'b011;
		@(posedge pclk); ddr_wr <= 1'b0;
		@(posedge pclk);
		chk("ddr locks", {29'h0, ddr_q}, 32'h5);
		chk("tx irq", {31'h0, irq}, 32'h1);
		// line idle for more than ten bit times: arming wake-up is refused
		repeat (200) @(posedge pclk);
		wr(CSR_ADDR, 8'h1F);
		rd(CSR_ADDR); chk("wake refused", rd_val, 32'h3E);
		// one random byte at each of the three shorter rates
		for (int s = 0; s < 3; s++) begin
			wr(RATE_ADDR, 8'h04 | s[7:0]);
			far_u.bit_cycles = 16 << (3 * s);
			b1 = 8'($urandom);
			rd(CSR_ADDR);
			wr(TXD_ADDR, b1);
			exp_q.push_back(b1);
			k = 0;
			while (exp_q.size() > 0 && k < 20000) begin
				@(posedge pclk);
				k++;
			end
			chk("tx sent", exp_q.size(), 32'h0);
		end
		// receive path with transmit interrupt off
		far_u.bit_cycles = 16;
		wr(RATE_ADDR, 8'h04);
		wr(CSR_ADDR, 8'h1A);
		b1 = 8'($urandom);
		b2 = 8'($urandom);
		far_u.send(b1, 1'b1);
		rd(CSR_ADDR); chk("rx full", rd_val, 32'hBA);
		chk("rx irq", {31'h0, irq}, 32'h1);
		rd(RXD_ADDR); chk("rx data", rd_val, {24'h0, b1});
		rd(CSR_ADDR); chk("rx clear", rd_val, 32'h3A);
		far_u.send(b1, 1'b1);
		far_u.send(b2, 1'b1);
		rd(CSR_ADDR); chk("overrun", rd_val, 32'hFA);
		rd(RXD_ADDR); chk("overrun data", rd_val, {24'h0, b1});
		rd(CSR_ADDR); chk("overrun clear", rd_val, 32'h3A);
		// framing error, then a good frame that must be held back
		far_u.send(b2, 1'b0);
		repeat (200) @(posedge pclk);
		far_u.send(b1, 1'b1);
		rd(CSR_ADDR); chk("framing", rd_val, 32'h7A);
		rd(RXD_ADDR); chk("framing data", rd_val, {24'h0, b2});
		rd(CSR_ADDR); chk("framing clear", rd_val, 32'h3A);
		chk("irq quiet", {31'h0, irq}, 32'h0);
		// transmitter off, then the clock pin codes
		wr(CSR_ADDR, 8'h08);
		@(posedge pclk);
		chk("tx off", {30'h0, tx_out, ddr_q[2]}, 32'h3);
		wr(RATE_ADDR, 8'h08);
		toggles(1'b0, k);
		chk("clock out", k, 32'h8);
		chk("clkpin out", {31'h0, ddr_q[0]}, 32'h1);
		wr(RATE_ADDR, 8'h0C);
		@(posedge pclk); ddr_wr <= 1'b1; ddr_wdata <= 3'b111;
		@(posedge pclk); ddr_wr <= 1'b0;
		@(posedge pclk);
		chk("clkpin in", {29'h0, ddr_q}, 32'h4);
		// external eight-times clock: one framed byte at 64 cycles a bit
		far_u.bit_cycles = 64;
		wr(CSR_ADDR, 8'h02);
		b1 = 8'($urandom);
		rd(CSR_ADDR);
		wr(TXD_ADDR, b1);
		exp_q.push_back(b1);
		k = 0;
		while (exp_q.size() > 0 && k < 20000) begin
			@(posedge pclk);
			k++;
		end
		chk("ext tx sent", exp_q.size(), 32'h0);
		// bi-phase output follows next; its edges are not frames
		far_u.listen = 1'b0;
		wr(RATE_ADDR, 8'h00);
		chk("clkpin kept", {31'h0, ddr_q[0], clk_out}, 32'h0);
		// bi-phase idle ones: two transitions per bit time
		far_u.listen = 1'b0;
		wr(CSR_ADDR, 8'h02);
		toggles(1'b1, k);
		chk("biphase", k, 32'h8);
		results();
	end
endmodule // tb_top
